// ==== logic/lpm_cfg.svh ====
// Constants for the low-power mode controller.
// Assumes one 40 MHz core clock; included by bare name.
// What this block does
// - Stop keeps RAM and registers while the core clock, the PLL and the fast oscillators are stopped.
// - In stop the core regulator is held in its low-power setting, not switched off.
// - Any enabled external event line wakes the device from stop within 8 us.
// - Stop wake sources are 16 external lines, the voltage detector and the comparators when the reference is on.
// - A USB wake-up indication also ends stop.
// - Standby with clock keeps one low-speed oscillator and turns off regulator, PLL and fast oscillators.
// - Standby without clock also turns off the low-speed crystal, and the low-speed internal oscillator unless the watchdog is enabled.
// - Standby drops core contents except the standby circuitry and clock status register.
// - Standby with clock ends within 60 us on reset pin, watchdog, wake pin edge or clock events.
// - Standby without clock ends within 60 us only on reset pin or a wake pin rising edge.
// - Entering stop or standby with clock does not by itself stop the clock, the watchdog or their sources.
`ifndef LPM_CFG_SVH
`define LPM_CFG_SVH
`define LPM_CLK_MHZ        40
`define LPM_STOP_WAKE_NS   8000
`define LPM_STBY_WAKE_NS   60000
`define LPM_STOP_WAKE_CYC  ((`LPM_STOP_WAKE_NS * `LPM_CLK_MHZ) / 1000)
`define LPM_STBY_WAKE_CYC  ((`LPM_STBY_WAKE_NS * `LPM_CLK_MHZ) / 1000)
`define LPM_EXT_LINES      16
`define LPM_WAKE_PINS      3
`define LPM_RST_HOLD_CYC   8
`endif

// ==== logic/lpm_pkg.sv ====
// Types for the low-power mode controller.
// Assumes nothing of its surroundings.
package lpm_pkg;
  typedef enum logic [1:0] {
    REQ_RUN,
    REQ_STOP,
    REQ_STBY_CLK,
    REQ_STBY_NOCLK
  } lpm_req_e;
  typedef enum logic [2:0] {
    ST_RUN,
    ST_STOP,
    ST_STOP_WAKE,
    ST_STBY,
    ST_STBY_WAKE,
    ST_RESET
  } lpm_state_e;
endpackage : lpm_pkg

// ==== logic/wake_bus_if.sv ====
// Wake request bundle from the source gating to the sequencer.
// Assumes one clock domain.
`timescale 1ns/1ps
`default_nettype none
interface wake_bus_if;
  logic stopWake;
  logic stbyWake;
  modport src  (output stopWake, output stbyWake);
  modport sink (input stopWake, input stbyWake);
endinterface : wake_bus_if
`default_nettype wire

// ==== logic/wake_source_gate.sv ====
// Combines and gates the wake sources for each low-power state.
// Assumes sources are synchronous levels; wake pins are edge detected here.
`timescale 1ns/1ps
`default_nettype none
`include "lpm_cfg.svh"
module wake_source_gate
  import lpm_pkg::*;
#(
  parameter int NLINES = `LPM_EXT_LINES,
  parameter int NPINS  = `LPM_WAKE_PINS
) (
  input  wire logic              core_clk,
  input  wire logic              external_reset_pin,
  input  wire logic              rtcKept,
  input  wire logic [NLINES-1:0] extLine,
  input  wire logic [NLINES-1:0] extLineEn,
  input  wire logic              supplyVoltageDetector,
  input  wire logic              comp1Event,
  input  wire logic              comp2Event,
  input  wire logic              vrefOn,
  input  wire logic              usbWake,
  input  wire logic [NPINS-1:0]  wakePin,
  input  wire logic [NPINS-1:0]  wakePinEn,
  input  wire logic              extResetPin,
  input  wire logic              watchdogReset,
  input  wire logic              rtcEvent,
  wake_bus_if.src                wb
);
  logic [NPINS-1:0] pinPrev_q;
  logic [NPINS-1:0] pinPrev_d;
  logic [NPINS-1:0] pinRise;

  always_comb begin
    pinPrev_d = wakePin;
  end

  always_ff @(posedge core_clk or negedge external_reset_pin) begin
    if (!external_reset_pin) begin
      pinPrev_q <= '0;
    end else begin
      pinPrev_q <= pinPrev_d;
    end
  end

  genvar i;
  generate
    for (i = 0; i < NPINS; i++) begin : gRise
      assign pinRise[i] = wakePin[i] & ~pinPrev_q[i] & wakePinEn[i];
    end
  endgenerate

  assign wb.stopWake = (|(extLine & extLineEn)) | supplyVoltageDetector
                     | (vrefOn & (comp1Event | comp2Event))
                     | usbWake;
  assign wb.stbyWake = extResetPin | (|pinRise)
                     | (rtcKept & (watchdogReset | rtcEvent));
endmodule : wake_source_gate
`default_nettype wire

// ==== logic/low_power_mode_controller.sv ====
// Sequencer for stop and standby states: gates clocks, oscillators,
// regulator and core retention. Assumes the core asks via modeReq/enterReq.
`timescale 1ns/1ps
`default_nettype none
`include "lpm_cfg.svh"
module low_power_mode_controller
  import lpm_pkg::*;
#(
  parameter int NLINES = `LPM_EXT_LINES,
  parameter int NPINS  = `LPM_WAKE_PINS
) (
  input  wire logic              core_clk,
  input  wire logic              external_reset_pin,
  input  wire logic              enterReq,
  input  wire logic [1:0]        modeReq,
  input  wire logic              lowSpeedUseCrystal,
  input  wire logic              rtcEnable,
  input  wire logic              watchdogEnable,
  input  wire logic [NLINES-1:0] extLine,
  input  wire logic [NLINES-1:0] extLineEn,
  input  wire logic              supplyVoltageDetector,
  input  wire logic              comp1Event,
  input  wire logic              comp2Event,
  input  wire logic              vrefOn,
  input  wire logic              usbWake,
  input  wire logic [NPINS-1:0]  wakePin,
  input  wire logic [NPINS-1:0]  wakePinEn,
  input  wire logic              extResetPin,
  input  wire logic              watchdogReset,
  input  wire logic              rtcEvent,
  output logic                   coreClkEn,
  output logic                   pllEn,
  output logic                   multispeedOscEn,
  output logic                   highSpeedIntOscEn,
  output logic                   highSpeedXtalOscEn,
  output logic                   lowSpeedIntOscEn,
  output logic                   lowSpeedXtalOscEn,
  output logic                   regulatorOn,
  output logic                   regulatorLowPower,
  output logic                   coreRetain,
  output logic                   coreReset_n,
  output logic                   inStop,
  output logic                   inStandby,
  output logic                   wakeDone
);
  localparam int STOP_CYC = `LPM_STOP_WAKE_CYC;
  localparam int STBY_CYC = `LPM_STBY_WAKE_CYC;
  localparam int CW       = $clog2(STBY_CYC + 1);

  if (NLINES < 1 || NPINS < 1 || STOP_CYC < 1 || STOP_CYC > STBY_CYC) begin : gBadParams
    $error("low_power_mode_controller: bad parameters");
  end

  logic        rtcKept_q;
  logic        rtcKept_d;

  wake_bus_if wb ();

  wake_source_gate #(
    .NLINES (NLINES),
    .NPINS  (NPINS)
  ) uGate (
    .core_clk              (core_clk),
    .external_reset_pin                  (external_reset_pin),
    .rtcKept               (rtcKept_q),
    .extLine               (extLine),
    .extLineEn             (extLineEn),
    .supplyVoltageDetector (supplyVoltageDetector),
    .comp1Event            (comp1Event),
    .comp2Event            (comp2Event),
    .vrefOn                (vrefOn),
    .usbWake               (usbWake),
    .wakePin               (wakePin),
    .wakePinEn             (wakePinEn),
    .extResetPin           (extResetPin),
    .watchdogReset         (watchdogReset),
    .rtcEvent              (rtcEvent),
    .wb                    (wb.src)
  );

  // ---------------------------------------------------------------
  // State sequencing
  // ---------------------------------------------------------------
  lpm_state_e  state_q;
  lpm_state_e  state_d;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic        xtal_q;
  logic        xtal_d;
  logic        done_q;
  logic        done_d;

  always_comb begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    rtcKept_d = rtcKept_q;
    xtal_d    = xtal_q;
    done_d    = 1'b0;
    unique case (state_q)
      ST_RUN: begin
        if (enterReq) begin
          unique case (lpm_req_e'(modeReq))
            REQ_STOP: begin
              state_d = ST_STOP;
            end
            REQ_STBY_CLK: begin
              state_d   = ST_STBY;
              rtcKept_d = 1'b1;
              xtal_d    = lowSpeedUseCrystal;
            end
            REQ_STBY_NOCLK: begin
              state_d   = ST_STBY;
              rtcKept_d = 1'b0;
            end
            REQ_RUN: begin
              state_d = ST_RUN;
            end
          endcase
        end
      end
      ST_STOP: begin
        if (wb.stopWake) begin
          state_d = ST_STOP_WAKE;
          cnt_d   = CW'(STOP_CYC - 1);
        end
      end
      ST_STOP_WAKE: begin
        // Oscillators restart during the count; state was retained
        if (cnt_q == '0) begin
          state_d = ST_RUN;
          done_d  = 1'b1;
        end else begin
          cnt_d = cnt_q - CW'(1);
        end
      end
      ST_STBY: begin
        if (wb.stbyWake) begin
          state_d = ST_STBY_WAKE;
          cnt_d   = CW'(STBY_CYC - 1 - `LPM_RST_HOLD_CYC);
        end
      end
      ST_STBY_WAKE: begin
        if (cnt_q == '0) begin
          state_d = ST_RESET;
          cnt_d   = CW'(`LPM_RST_HOLD_CYC - 1);
        end else begin
          cnt_d = cnt_q - CW'(1);
        end
      end
      ST_RESET: begin
        // Core comes back through reset: contents were lost
        if (cnt_q == '0) begin
          state_d   = ST_RUN;
          rtcKept_d = 1'b0;
          done_d    = 1'b1;
        end else begin
          cnt_d = cnt_q - CW'(1);
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge external_reset_pin) begin
    if (!external_reset_pin) begin
      state_q   <= ST_RUN;
      cnt_q     <= '0;
      rtcKept_q <= 1'b0;
      xtal_q    <= 1'b0;
      done_q    <= 1'b0;
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      rtcKept_q <= rtcKept_d;
      xtal_q    <= xtal_d;
      done_q    <= done_d;
    end
  end

  // ---------------------------------------------------------------
  // Power and clock controls
  // ---------------------------------------------------------------
  // Decoded from the next state and held in flops, so each control
  // moves on the same edge as the state it belongs to
  logic coreClkEn_q;
  logic coreClkEn_d;
  logic pllEn_q;
  logic pllEn_d;
  logic multispeedOscEn_q;
  logic multispeedOscEn_d;
  logic highSpeedIntOscEn_q;
  logic highSpeedIntOscEn_d;
  logic highSpeedXtalOscEn_q;
  logic highSpeedXtalOscEn_d;
  logic lowSpeedIntOscEn_q;
  logic lowSpeedIntOscEn_d;
  logic lowSpeedXtalOscEn_q;
  logic lowSpeedXtalOscEn_d;
  logic regulatorOn_q;
  logic regulatorOn_d;
  logic regulatorLowPower_q;
  logic regulatorLowPower_d;
  logic coreRetain_q;
  logic coreRetain_d;
  logic coreReset_n_q;
  logic coreReset_n_d;
  logic inStop_q;
  logic inStop_d;
  logic inStandby_q;
  logic inStandby_d;

  always_comb begin
    coreClkEn_d          = 1'b1;
    pllEn_d              = 1'b1;
    multispeedOscEn_d    = 1'b1;
    highSpeedIntOscEn_d  = 1'b1;
    highSpeedXtalOscEn_d = 1'b1;
    lowSpeedIntOscEn_d   = 1'b1;
    lowSpeedXtalOscEn_d  = 1'b1;
    regulatorOn_d        = 1'b1;
    regulatorLowPower_d  = 1'b0;
    coreRetain_d         = 1'b1;
    coreReset_n_d        = 1'b1;
    inStop_d             = 1'b0;
    inStandby_d          = 1'b0;
    unique case (state_d)
      ST_RUN: begin
      end
      ST_STOP: begin
        coreClkEn_d          = 1'b0;
        pllEn_d              = 1'b0;
        multispeedOscEn_d    = 1'b0;
        highSpeedIntOscEn_d  = 1'b0;
        highSpeedXtalOscEn_d = 1'b0;
        // Clock and watchdog users keep their low-speed source alive
        lowSpeedIntOscEn_d   = rtcEnable || watchdogEnable;
        lowSpeedXtalOscEn_d  = rtcEnable;
        regulatorLowPower_d  = 1'b1;
        inStop_d             = 1'b1;
      end
      ST_STOP_WAKE: begin
        // Oscillators settle before the core clock is let through
        coreClkEn_d = 1'b0;
      end
      ST_STBY, ST_STBY_WAKE: begin
        coreClkEn_d          = 1'b0;
        pllEn_d              = 1'b0;
        multispeedOscEn_d    = 1'b0;
        highSpeedIntOscEn_d  = 1'b0;
        highSpeedXtalOscEn_d = 1'b0;
        lowSpeedIntOscEn_d   = (rtcKept_d && !xtal_d) || watchdogEnable;
        lowSpeedXtalOscEn_d  = rtcKept_d && xtal_d;
        regulatorOn_d        = 1'b0;
        coreRetain_d         = 1'b0;
        coreReset_n_d        = 1'b0;
        inStandby_d          = 1'b1;
      end
      ST_RESET: begin
        coreReset_n_d = 1'b0;
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge external_reset_pin) begin
    if (!external_reset_pin) begin
      coreClkEn_q          <= 1'b1;
      pllEn_q              <= 1'b1;
      multispeedOscEn_q    <= 1'b1;
      highSpeedIntOscEn_q  <= 1'b1;
      highSpeedXtalOscEn_q <= 1'b1;
      lowSpeedIntOscEn_q   <= 1'b1;
      lowSpeedXtalOscEn_q  <= 1'b1;
      regulatorOn_q        <= 1'b1;
      regulatorLowPower_q  <= 1'b0;
      coreRetain_q         <= 1'b1;
      coreReset_n_q        <= 1'b1;
      inStop_q             <= 1'b0;
      inStandby_q          <= 1'b0;
    end else begin
      coreClkEn_q          <= coreClkEn_d;
      pllEn_q              <= pllEn_d;
      multispeedOscEn_q    <= multispeedOscEn_d;
      highSpeedIntOscEn_q  <= highSpeedIntOscEn_d;
      highSpeedXtalOscEn_q <= highSpeedXtalOscEn_d;
      lowSpeedIntOscEn_q   <= lowSpeedIntOscEn_d;
      lowSpeedXtalOscEn_q  <= lowSpeedXtalOscEn_d;
      regulatorOn_q        <= regulatorOn_d;
      regulatorLowPower_q  <= regulatorLowPower_d;
      coreRetain_q         <= coreRetain_d;
      coreReset_n_q        <= coreReset_n_d;
      inStop_q             <= inStop_d;
      inStandby_q          <= inStandby_d;
    end
  end

  assign coreClkEn          = coreClkEn_q;
  assign pllEn              = pllEn_q;
  assign multispeedOscEn    = multispeedOscEn_q;
  assign highSpeedIntOscEn  = highSpeedIntOscEn_q;
  assign highSpeedXtalOscEn = highSpeedXtalOscEn_q;
  assign lowSpeedIntOscEn   = lowSpeedIntOscEn_q;
  assign lowSpeedXtalOscEn  = lowSpeedXtalOscEn_q;
  assign regulatorOn        = regulatorOn_q;
  assign regulatorLowPower  = regulatorLowPower_q;
  assign coreRetain         = coreRetain_q;
  assign coreReset_n        = coreReset_n_q;
  assign inStop             = inStop_q;
  assign inStandby          = inStandby_q;
  assign wakeDone           = done_q;
endmodule : low_power_mode_controller
`default_nettype wire

// ==== testbench/lpm_monitor.sv ====
// Checker on the low-power mode controller's top-level ports.
// Assumes one clock domain; bound into every controller instance.
`timescale 1ns/1ps
`default_nettype none
module lpm_monitor #(
  parameter int NLINES = 16
) (
  input wire logic              core_clk,
  input wire logic              external_reset_pin,
  input wire logic [NLINES-1:0] extLine,
  input wire logic [NLINES-1:0] extLineEn,
  input wire logic              supplyVoltageDetector,
  input wire logic              comp1Event,
  input wire logic              comp2Event,
  input wire logic              vrefOn,
  input wire logic              usbWake,
  input wire logic              extResetPin,
  input wire logic              watchdogEnable,
  input wire logic              coreClkEn,
  input wire logic              pllEn,
  input wire logic              multispeedOscEn,
  input wire logic              highSpeedIntOscEn,
  input wire logic              highSpeedXtalOscEn,
  input wire logic              lowSpeedIntOscEn,
  input wire logic              regulatorOn,
  input wire logic              regulatorLowPower,
  input wire logic              coreRetain,
  input wire logic              coreReset_n,
  input wire logic              inStop,
  input wire logic              inStandby,
  input wire logic              wakeDone
);
  logic        stopSrc;
  logic        fastOn;
  logic        stbyWait_q;
  logic        stbyWait_d;
  logic [11:0] stbyWaitCnt_q;
  logic [11:0] stbyWaitCnt_d;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!external_reset_pin);
  assign stopSrc = |(extLine & extLineEn) | supplyVoltageDetector | usbWake | (vrefOn & (comp1Event | comp2Event));
  assign fastOn = pllEn | multispeedOscEn | highSpeedIntOscEn | highSpeedXtalOscEn;
  // Cycles since a reset-pin wake in standby; too long for a delay range
  always_comb begin
    stbyWait_d    = stbyWait_q;
    stbyWaitCnt_d = stbyWaitCnt_q;
    if (wakeDone) begin
      stbyWait_d    = 1'b0;
      stbyWaitCnt_d = 12'h000;
    end else if (stbyWait_q) begin
      stbyWaitCnt_d = stbyWaitCnt_q + 12'h001;
    end else if (inStandby && extResetPin) begin
      stbyWait_d = 1'b1;
    end
  end
  always_ff @(posedge core_clk or negedge external_reset_pin) begin
    if (!external_reset_pin) begin
      stbyWait_q    <= 1'b0;
      stbyWaitCnt_q <= 12'h000;
    end else begin
      stbyWait_q    <= stbyWait_d;
      stbyWaitCnt_q <= stbyWaitCnt_d;
    end
  end
  a_stop_clocks_off: assert property (inStop |-> !(coreClkEn | fastOn) && coreRetain)
    else $error("clock running in stop");
  a_stop_reg_low: assert property (inStop |-> regulatorOn && regulatorLowPower)
    else $error("regulator not low power in stop");
  a_stop_wake_time: assert property (inStop && stopSrc |-> ##[1:322] wakeDone)
    else $error("stop wake too slow");
  a_stop_src_gate: assert property (inStop && !stopSrc |=> inStop)
    else $error("stop left without a source");
  a_stby_power_off: assert property (inStandby |-> !(regulatorOn | fastOn | coreRetain | coreReset_n))
    else $error("core domain alive in standby");
  a_stby_wake_time: assert property (stbyWait_q |-> stbyWaitCnt_q <= 12'h961)
    else $error("standby wake too slow");
  a_stby_reset_exit: assert property ($fell(inStandby) |-> !coreReset_n [*8] ##1 (coreReset_n && wakeDone))
    else $error("standby exit skipped reset hold");
  a_watchdog_osc: assert property ($past(watchdogEnable) |-> lowSpeedIntOscEn)
    else $error("watchdog clock stopped");
endmodule : lpm_monitor
bind low_power_mode_controller lpm_monitor #(.NLINES(NLINES)) mon (.*);
`default_nettype wire

// ==== testbench/wake_partner.sv ====
// Far-side model: wake pins, reset pin and wake event sources.
// Assumes a fire pulse picks one source, held high four cycles.
`timescale 1ns/1ps
`default_nettype none
module wake_partner #(
  parameter int NLINES = 16,
  parameter int NPINS  = 3
) (
  input wire logic               core_clk,
  input wire logic               fire,
  input wire logic [3:0]         kind,
  input wire logic [3:0]         idx,
  output logic     [NLINES-1:0]  extLine,
  output logic                   supplyVoltageDetector,
  output logic                   comp1Event,
  output logic                   comp2Event,
  output logic                   usbWake,
  output logic     [NPINS-1:0]   wakePin,
  output logic                   extResetPin,
  output logic                   watchdogReset,
  output logic                   rtcEvent
);
  logic [2:0] holdQ = 3'h0;
  logic [3:0] kindQ;
  logic [3:0] idxQ;
  logic       act;
  always @(posedge core_clk) begin
    if (fire) begin
      holdQ <= 3'h4;
      kindQ <= kind;
      idxQ  <= idx;
    end else if (holdQ != 3'h0) begin
      holdQ <= holdQ - 3'h1;
    end
  end
  // Released sources return low, so every wake pin sees a fresh rising edge
  assign act = (holdQ != 3'h0);
  assign extLine = (act && kindQ == 4'h0) ? NLINES'(1) << idxQ : '0;
  assign supplyVoltageDetector = act && kindQ == 4'h1;
  assign comp1Event = act && kindQ == 4'h2;
  assign comp2Event = act && kindQ == 4'h3;
  assign usbWake = act && kindQ == 4'h4;
  assign wakePin = (act && kindQ == 4'h5) ? NPINS'(1) << idxQ : '0;
  assign extResetPin = act && kindQ == 4'h6;
  assign watchdogReset = act && kindQ == 4'h7;
  assign rtcEvent = act && kindQ == 4'h8;
endmodule : wake_partner
`default_nettype wire

// ==== testbench/testbench.sv ====
// Self-checking bench for the low-power mode controller.
// Assumes the wake partner drives every wake source.
`timescale 1ns/1ps
`default_nettype none
`include "lpm_cfg.svh"
module testbench;
  import lpm_pkg::*;
  logic        core_clk, external_reset_pin, enterReq, lowSpeedUseCrystal, rtcEnable, watchdogEnable, vrefOn, fire;
  logic [1:0]  modeReq;
  logic [15:0] extLine, extLineEn;
  logic [2:0]  wakePin, wakePinEn;
  logic [3:0]  kind, idx;
  logic        supplyVoltageDetector, comp1Event, comp2Event, usbWake, extResetPin, watchdogReset, rtcEvent;
  logic        coreClkEn, pllEn, multispeedOscEn, highSpeedIntOscEn, highSpeedXtalOscEn, lowSpeedIntOscEn;
  logic        lowSpeedXtalOscEn, regulatorOn, regulatorLowPower, coreRetain, coreReset_n, inStop, inStandby;
  logic        wakeDone;
  int          badCount, totalChecks;
  low_power_mode_controller dut (.core_clk, .external_reset_pin, .enterReq, .modeReq, .lowSpeedUseCrystal, .rtcEnable,
    .watchdogEnable, .extLine, .extLineEn, .supplyVoltageDetector, .comp1Event, .comp2Event, .vrefOn, .usbWake,
    .wakePin, .wakePinEn, .extResetPin, .watchdogReset, .rtcEvent, .coreClkEn, .pllEn, .multispeedOscEn,
    .highSpeedIntOscEn, .highSpeedXtalOscEn, .lowSpeedIntOscEn, .lowSpeedXtalOscEn, .regulatorOn,
    .regulatorLowPower, .coreRetain, .coreReset_n, .inStop, .inStandby, .wakeDone);
  wake_partner far (.core_clk, .fire, .kind, .idx, .extLine, .supplyVoltageDetector, .comp1Event, .comp2Event,
    .usbWake, .wakePin, .extResetPin, .watchdogReset, .rtcEvent);
  task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      badCount++;
      $display("MISMATCH %s expected %0h seen %0h", n, exp, seen);
    end
  endtask : check
  task automatic giveVerdict;
    $display("checks %0d mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : giveVerdict
  task automatic enter(input lpm_req_e m);
    @(posedge core_clk) begin
      enterReq <= 1'b1;
      modeReq  <= m;
    end
    @(posedge core_clk) enterReq <= 1'b0;
    #1;
  endtask : enter
  // Counts from the edge the partner raises the source; a hang ends the run
  task automatic wake(input logic [3:0] k, input logic [3:0] i, input int lim, input logic exp);
    logic woke;
    woke = 1'b0;
    @(posedge core_clk) begin
      fire <= 1'b1;
      kind <= k;
      idx  <= i;
    end
    @(posedge core_clk) fire <= 1'b0;
    for (int n = 0; n < lim && !woke; n++) begin
      @(posedge core_clk) #1;
      woke = (wakeDone === 1'b1);
    end
    check("woke", woke, exp);
    if (exp && !woke) giveVerdict();
  endtask : wake
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic stopWake;
    logic [3:0] ks [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4};
    enter(REQ_RUN);
    check("runHeld", {inStop, inStandby, coreClkEn}, 16'h1);
    enter(REQ_STOP);
    check("stopClk", {coreClkEn, pllEn, multispeedOscEn, highSpeedIntOscEn, highSpeedXtalOscEn}, 16'h0);
    check("stopReg", {regulatorOn, regulatorLowPower, coreRetain}, 16'h7);
    check("stopLs", {lowSpeedIntOscEn, lowSpeedXtalOscEn}, 16'h3);
    wake(4'h2, 4'h0, 40, 1'b0);
    wake(4'h0, 4'h0, 40, 1'b0);
    check("stopHeld", inStop, 1'b1);
    @(posedge core_clk) vrefOn <= 1'b1;
    foreach (ks[j]) begin
      if (j != 0) enter(REQ_STOP);
      wake(ks[j], 4'hF, `LPM_STOP_WAKE_CYC + 3, 1'b1);
      check("runClk", coreClkEn, 1'b1);
    end
  endtask : stopWake
  task automatic standbyClock;
    logic [3:0] ks [4] = '{4'h6, 4'h7, 4'h8, 4'h5};
    foreach (ks[j]) begin
      enter(REQ_STBY_CLK);
      check("stbyOff", {regulatorOn, pllEn, multispeedOscEn, highSpeedIntOscEn, coreRetain, coreReset_n}, 16'h0);
      check("stbyXtal", lowSpeedXtalOscEn, 1'b1);
      wake(ks[j], 4'h2, `LPM_STBY_WAKE_CYC + 3, 1'b1);
      check("rstOut", {coreReset_n, inStandby}, 16'h2);
    end
    @(posedge core_clk) lowSpeedUseCrystal <= 1'b0;
    enter(REQ_STBY_CLK);
    check("stbyLsInt", {lowSpeedIntOscEn, lowSpeedXtalOscEn}, 16'h2);
    wake(4'h5, 4'h1, `LPM_STBY_WAKE_CYC + 3, 1'b1);
  endtask : standbyClock
  task automatic standbyNoClock;
    @(posedge core_clk) begin
      rtcEnable      <= 1'b0;
      watchdogEnable <= 1'b0;
    end
    enter(REQ_STBY_NOCLK);
    check("lsOff", {lowSpeedIntOscEn, lowSpeedXtalOscEn, highSpeedXtalOscEn}, 16'h0);
    wake(4'h8, 4'h0, 100, 1'b0);
    wake(4'h7, 4'h0, 100, 1'b0);
    check("stbyHeld", inStandby, 1'b1);
    wake(4'h5, 4'h0, `LPM_STBY_WAKE_CYC + 3, 1'b1);
  endtask : standbyNoClock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    {external_reset_pin, enterReq, modeReq, vrefOn, fire, kind, idx} = '0;
    {lowSpeedUseCrystal, rtcEnable, watchdogEnable} = 3'h7;
    extLineEn = 16'h8000;
    wakePinEn = 3'h7;
    repeat (10) @(posedge core_clk);
    external_reset_pin <= 1'b1;
    stopWake();
    standbyClock();
    standbyNoClock();
    giveVerdict();
  end
endmodule : testbench
`default_nettype wire
